// file: rtl/rss_map.svh
// Register offsets, field positions, reset values and timing counts for the reset sequencer.
// Assumes a 50 MHz clock and a word-addressed Avalon-MM slave with 32-bit data.
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH
`define RSS_ADDR_W 2
`define RSS_BROWNOUT_CONTROL_OFS 2'h0
`define RSS_RESET_CAUSE_OFS 2'h1
`define RSS_STATUS_FLAGS_OFS 2'h2
`define RSS_BOC_SWEN_BIT 7
`define RSS_BOC_FAST_BIT 6
`define RSS_BOC_READY_BIT 0
`define RSS_BOC_RESET 2'h2
`define RSS_CAUSE_RESET 8'h1c
`define RSS_CAUSE_WMASK 8'hdf
`define RSS_STAT_RESET 2'h3
`define RSS_CLK_HZ 50000000
`define RSS_PUD_MS 64
`define RSS_PUD_CYC ((`RSS_PUD_MS * (`RSS_CLK_HZ / 1000)))
`define RSS_BOD_NS 1000
`define RSS_BOD_CYC ((`RSS_BOD_NS * (`RSS_CLK_HZ / 1000000) + 999) / 1000)
`define RSS_PIN_FILT_NS 200
`define RSS_PIN_FILT_CYC ((`RSS_PIN_FILT_NS * (`RSS_CLK_HZ / 1000000) + 999) / 1000)
`define RSS_START_CYC 10
`define RSS_CNT_W 23
`endif

// file: rtl/rss_pkg.sv
// Types for the reset source sequencer.
// Assumes rss_map.svh supplies all numeric constants.
package rss_pkg;
  typedef enum logic [1:0] {
    RSS_BO_OFF = 2'b00,
    RSS_BO_SW = 2'b01,
    RSS_BO_NOSLEEP = 2'b10,
    RSS_BO_ON = 2'b11
  } rss_bo_mode_t;
  typedef enum logic [1:0] {
    RSS_ST_HOLD = 2'b00,
    RSS_ST_DELAY = 2'b01,
    RSS_ST_WAITPIN = 2'b10,
    RSS_ST_RUN = 2'b11
  } rss_state_t;
endpackage

// file: rtl/rss_reset_source_sequencer.sv
// Reset source sequencer: combines all reset causes, runs the power-up delay and records the cause.
// Assumes all inputs synchronous to clk; Avalon-MM slave, one wait state on every access.
//
// Overview of operation
// - Power-up delay lasts 64 ms after power events
// - Core held in reset while delay runs
// - Delay starts after power-on and brown-out release
// - Mode field picks on, nosleep, software, off
// - Mode 11: always active, wake not delayed
// - Mode 10: off in sleep, waits ready
// - Mode 01: software enable, no start wait
// - Software mode: protect once ready, sleep-neutral
// - Software enable acts only in mode 01
// - Fast start forces reference in modes 10/01
// - Ready bit reflects brown-out circuit activity
// - Short supply dips are filtered out
// - Low-power detector resets, clears brown-out flag
// - Low-power detector enabled by configuration bit
// - Pin enabled by pin-enable or low-voltage programming
// - Enabled low pin holds reset, glitches ignored
// - Reset logic never drives the pin
// - Disabled pin is plain input, software pull-up
// - Watchdog time-out resets, updates status flags
// - Reset instruction resets, clears its flag
// - Stack faults reset only when enabled
// - Programming exit acts as power-on reset
// - Delay ignores pin; start 10 cycles after
// - Run needs delay done and pin released
//
// Structure
// Combinational decode of the configured brown-out mode first.
// Then two filters: one for supply dips, one for the pin.
// The sequencer walks hold, delay, pin wait and run.
// Hold lasts while any power-class event is present.
// Delay counts the power-up time unless it is disabled.
// Pin wait needs a filtered release plus a short gap.
// Run drops the core reset at the edge it is entered.
//
// Power-class versus hard sources
// Power-on, programming exit and filtered brown-out are power-class.
// They restart the whole sequence, including the delay.
// Watchdog, reset instruction and enabled stack faults are hard.
// Hard sources skip the delay and only redo the gap.
// This keeps a watchdog loop from costing a full delay each time.
//
// Brown-out handling
// Mode decode is cheap, so it is redone every cycle.
// Configuration bits may therefore change at any time.
// Protection counts only while the circuit reports ready.
// The low-power detector shares the same dip filter.
// Limitation: both detectors share one filter count.
// A dip seen by either keeps the filter running.
//
// Pin handling
// The pin filter is symmetric on purpose.
// A short high during a held-low pin must not release the core.
// The pin is never driven; its enable and value stay low.
// When the pin is disabled it becomes a plain sampled input.
//
// Cause flags
// Active-low flags are cleared by hardware, set by software.
// Stack flags are active high, set by hardware.
// A hardware event beats a software write in the same cycle.
// Power-on and programming exit reload the whole cause register; brown-out clears only bit 0.
//
// Register bus
// Every access takes exactly one wait state.
// The acknowledge is registered, which keeps timing short.
// Read data stays until the next read completes.
// Unmapped words read zero and ignore writes.
//
// Timing figures
// All counts but the start gap follow from the clock rate in the map header.
// The delay count is a parameter so benches can shorten it.
// The start gap is counted in clock cycles, not time.
//
// Outputs
// Every output comes straight from a flip-flop.
// Core reset is built from the next state to avoid a lag.
//
// Hazards
// Inputs are taken as already synchronous; no synchroniser here.
// A caller feeding raw pads must add synchronisers outside.
// Mode codes are all legal, so no default branch is needed.
// Bus reset restores the control bits; device resets do not.
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "rss_map.svh"
module rss_reset_source_sequencer
  import rss_pkg::*;
#(
  parameter int PUD_CYCLES = `RSS_PUD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`RSS_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic powerOnLow,
  input wire logic supplyLow,
  input wire logic brownOutCircuitActive,
  input wire logic lowPowerSupplyLow,
  input wire logic programModeExit,
  input wire logic externalResetPinIn,
  input wire logic softPullUpEnable,
  input wire logic sleepMode,
  input wire logic watchdogTimeout,
  input wire logic resetInstruction,
  input wire logic stackOverflow,
  input wire logic stackUnderflow,
  input wire logic [1:0] brownOutModeField,
  input wire logic powerUpDelayEnable_n,
  input wire logic lowPowerBrownOutEnable_n,
  input wire logic externalResetPinEnable,
  input wire logic lowVoltageProgEnable,
  input wire logic stackResetEnable,
  output logic coreReset,
  output logic brownOutDetectEnable,
  output logic referenceForceOn,
  output logic externalResetPinOut,
  output logic externalResetPinOe,
  output logic pinPullUpEnable,
  output logic generalInput
);

  rss_bo_mode_t boMode;
  rss_state_t state_q, state_d;
  logic swEnable_q, fastStart_q;
  logic [7:0] cause_q, cause_d;
  logic [1:0] statFlags_q, statFlags_d;
  logic [`RSS_CNT_W-1:0] pudCnt_q;
  logic [7:0] boFilt_q, pinFilt_q;
  logic [3:0] startCnt_q;
  logic pinLowF_q, boTrip_q, ack_q;
  logic [31:0] rdMux;

  assign boMode = rss_bo_mode_t'(brownOutModeField);

  // Brown-out detection enable per mode; sleep only matters in mode 10
  wire boActive = (boMode == RSS_BO_ON) ||
                  (boMode == RSS_BO_NOSLEEP && !sleepMode) ||
                  (boMode == RSS_BO_SW && swEnable_q);
  // Protection only counts once the circuit is ready
  wire boArmed = boActive && brownOutCircuitActive;
  wire lpEnabled = !lowPowerBrownOutEnable_n;
  wire pinEnabled = externalResetPinEnable || lowVoltageProgEnable;
  wire boLowRaw = (boArmed && supplyLow) || (lpEnabled && lowPowerSupplyLow);
  wire pinLowRaw = pinEnabled && !externalResetPinIn;
  // Modes 11 and 10 hold start-up for ready and supply; 01 and 00 do not
  wire startWaitBo = (boMode == RSS_BO_ON || boMode == RSS_BO_NOSLEEP) &&
                     (!brownOutCircuitActive || supplyLow);
  wire powerEvent = powerOnLow || programModeExit || boTrip_q;
  wire stackTrip = stackResetEnable && (stackOverflow || stackUnderflow);
  wire hardTrip = watchdogTimeout || resetInstruction || stackTrip;
  wire pudDone = powerUpDelayEnable_n || (pudCnt_q == `RSS_CNT_W'(PUD_CYCLES));
  wire busReq = (read || write) && !ack_q;
  wire wrHit = write && ack_q;

  // Filter for supply dips: must persist the minimum duration
  always_ff @(posedge clk) begin
    if (rst || !boLowRaw) begin
      boFilt_q <= 8'h00;
      boTrip_q <= 1'b0;
    end else if (boFilt_q == 8'(`RSS_BOD_CYC)) begin
      boTrip_q <= 1'b1;
    end else begin
      boFilt_q <= boFilt_q + 8'h01;
    end
  end

  // Pin glitch filter, symmetric so short highs do not release either
  always_ff @(posedge clk) begin
    if (rst) begin
      pinFilt_q <= 8'h00;
      pinLowF_q <= 1'b0;
    end else if (pinLowRaw == pinLowF_q) begin
      pinFilt_q <= 8'h00;
    end else if (pinFilt_q == 8'(`RSS_PIN_FILT_CYC)) begin
      pinLowF_q <= pinLowRaw;
      pinFilt_q <= 8'h00;
    end else begin
      pinFilt_q <= pinFilt_q + 8'h01;
    end
  end

  // Sequencer: power event holds, delay, then pin, then short start gap
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RSS_ST_HOLD: if (!powerEvent && !startWaitBo) begin
        state_d = RSS_ST_DELAY;
      end
      RSS_ST_DELAY: if (pudDone) begin
        state_d = RSS_ST_WAITPIN;
      end
      RSS_ST_WAITPIN: if (!pinLowF_q && startCnt_q == 4'(`RSS_START_CYC)) begin
        state_d = RSS_ST_RUN;
      end
      RSS_ST_RUN: if (pinLowF_q || hardTrip) begin
        state_d = RSS_ST_WAITPIN;
      end
    endcase
    if (powerEvent) begin
      state_d = RSS_ST_HOLD;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RSS_ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // Delay counter runs regardless of the pin; cleared by any power event
  always_ff @(posedge clk) begin
    if (rst || state_q == RSS_ST_HOLD) begin
      pudCnt_q <= '0;
    end else if (state_q == RSS_ST_DELAY && !pudDone) begin
      pudCnt_q <= pudCnt_q + `RSS_CNT_W'(1);
    end
  end

  // Start gap counts only while pin released and no hard source pending
  always_ff @(posedge clk) begin
    if (rst || state_q != RSS_ST_WAITPIN || pinLowF_q || hardTrip) begin
      startCnt_q <= 4'h0;
    end else if (startCnt_q != 4'(`RSS_START_CYC)) begin
      startCnt_q <= startCnt_q + 4'h1;
    end
  end

  // Cause flags; hardware events win over a software write in the same cycle
  always_comb begin
    cause_d = cause_q;
    statFlags_d = statFlags_q;
    if (wrHit && address == `RSS_RESET_CAUSE_OFS) begin
      cause_d = writedata[7:0] & `RSS_CAUSE_WMASK;
    end
    if (wrHit && address == `RSS_STATUS_FLAGS_OFS) begin
      statFlags_d = writedata[1:0];
    end
    if (powerOnLow || programModeExit) begin
      cause_d = `RSS_CAUSE_RESET;
      statFlags_d = `RSS_STAT_RESET;
    end else begin
      if (boTrip_q) begin
        cause_d[0] = 1'b0;
        statFlags_d = `RSS_STAT_RESET;
      end
      if (pinLowF_q && state_q == RSS_ST_RUN) begin
        cause_d[3] = 1'b0;
      end
      if (watchdogTimeout) begin
        cause_d[4] = 1'b0;
        statFlags_d[1] = 1'b0;
        statFlags_d[0] = !sleepMode;
      end
      if (resetInstruction) begin
        cause_d[2] = 1'b0;
      end
      if (stackTrip && stackOverflow) begin
        cause_d[7] = 1'b1;
      end
      if (stackTrip && stackUnderflow) begin
        cause_d[6] = 1'b1;
      end
    end
  end

  // Register writes; control bits survive every reset but the bus reset
  always_ff @(posedge clk) begin
    if (rst) begin
      swEnable_q <= 1'(`RSS_BOC_RESET >> 1);
      fastStart_q <= 1'b0;
      cause_q <= `RSS_CAUSE_RESET;
      statFlags_q <= `RSS_STAT_RESET;
    end else begin
      cause_q <= cause_d;
      statFlags_q <= statFlags_d;
      if (wrHit && address == `RSS_BROWNOUT_CONTROL_OFS) begin
        swEnable_q <= writedata[`RSS_BOC_SWEN_BIT];
        fastStart_q <= writedata[`RSS_BOC_FAST_BIT];
      end
    end
  end

  // Read data; ready bit is live circuit state
  assign rdMux = (address == `RSS_BROWNOUT_CONTROL_OFS) ?
                   {24'h000000, swEnable_q, fastStart_q, 5'h00, brownOutCircuitActive} :
                 (address == `RSS_RESET_CAUSE_OFS) ? {24'h000000, cause_q} :
                 (address == `RSS_STATUS_FLAGS_OFS) ? {30'h00000000, statFlags_q} : 32'h00000000;

  // One wait state: ack registered, so waitrequest drops a cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      ack_q <= busReq;
      waitrequest <= !busReq;
      if (busReq && read) begin
        readdata <= rdMux;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      coreReset <= 1'b1;
      brownOutDetectEnable <= 1'b0;
      referenceForceOn <= 1'b0;
      externalResetPinOut <= 1'b0;
      externalResetPinOe <= 1'b0;
      pinPullUpEnable <= 1'b0;
      generalInput <= 1'b0;
    end else begin
      coreReset <= (state_d != RSS_ST_RUN);
      brownOutDetectEnable <= boActive;
      referenceForceOn <= fastStart_q && (boMode == RSS_BO_NOSLEEP || boMode == RSS_BO_SW);
      externalResetPinOut <= 1'b0;
      externalResetPinOe <= 1'b0;
      pinPullUpEnable <= pinEnabled || softPullUpEnable;
      generalInput <= pinEnabled ? 1'b0 : externalResetPinIn;
    end
  end

endmodule

// file: tb/rss_reset_source_sequencer_tb_top.sv
// Bench for the reset source sequencer: registers, mode decoding and every reset source.
// Assumes a shortened power-up delay through PUD_CYCLES and the Avalon slave of the design.
`timescale 1ns/100ps
module rss_reset_source_sequencer_tb_top import rss_pkg::*;;
  localparam int PUD = 40;
  // Event table: bit7 pin low, 6 low-power dip, 5 supply dip, 4 prog exit, 3 wdog, 2 instr, 1 over, 0 under
  localparam logic [7:0] EV_VEC [12] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h10, 8'h20, 8'h20, 8'h40, 8'h80, 8'h80, 8'h80, 8'h80};
  localparam int EV_LEN [12] = '{1, 1, 1, 1, 1, 20, 80, 80, 5, 30, 30, 30};
  localparam logic [7:0] EV_CAUSE [12] = '{8'h0f, 8'h1b, 8'h9f, 8'h5f, 8'h1c, 8'h1f, 8'h1e, 8'h1e, 8'h1f, 8'h17, 8'h1f, 8'h17};
  localparam logic [2:0] EV_CFG [12] = '{3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 3'h6};
  localparam logic [11:0] EV_RST = 12'hadf;
  localparam logic [7:0] RST_VAL [4] = '{8'h81, 8'h1c, 8'h03, 8'h00};
  logic clk = 1'b0;
  logic rst, read, write, powerOnLow, readyIn, sleepMode, pullReq;
  logic [1:0] address;
  logic [31:0] writedata, readdata;
  logic [7:0] evt;
  logic [2:0] cfg;
  rss_bo_mode_t boMode;
  logic waitrequest, coreReset, detEn, refOn, pullEn, gpIn;
  int errTotal = 0;
  int nCompared = 0;
  rss_reset_source_sequencer #(.PUD_CYCLES(PUD)) dut (.clk, .rst, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .powerOnLow, .supplyLow(evt[5]), .brownOutCircuitActive(readyIn), .lowPowerSupplyLow(evt[6]),
    .programModeExit(evt[4]), .externalResetPinIn(!evt[7]), .softPullUpEnable(pullReq), .sleepMode,
    .watchdogTimeout(evt[3]), .resetInstruction(evt[2]), .stackOverflow(evt[1]), .stackUnderflow(evt[0]),
    .brownOutModeField(boMode), .powerUpDelayEnable_n(1'b0), .lowPowerBrownOutEnable_n(1'b0),
    .externalResetPinEnable(cfg[0]), .lowVoltageProgEnable(cfg[1]), .stackResetEnable(cfg[2]), .coreReset,
    .brownOutDetectEnable(detEn), .referenceForceOn(refOn), .externalResetPinOut(), .externalResetPinOe(),
    .pinPullUpEnable(pullEn), .generalInput(gpIn));
  // 50 MHz clock
  always #10 clk = ~clk;
  task automatic giveVerdict();
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    nCompared++;
    if (g !== e) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One Avalon access; leading edge keeps back-to-back calls from touching a strobe twice in one step
  task automatic bus(input logic [1:0] a, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    read <= 1'b0;
    write <= 1'b0;
    chk("waitrequest", 8'h0, {7'h0, waitrequest});
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk("readdata", e, readdata[7:0]);
  endtask
  task automatic waitRun();
    int n;
    n = 0;
    while (coreReset !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk("coreReset", 8'h0, {7'h0, coreReset});
  endtask
  // Hang guard, far beyond the expected run of under a thousand cycles
  initial begin
    cyc(20000);
    errTotal++;
    giveVerdict();
  end
  // Main sequence
  initial begin
    logic expD;
    {rst, read, write, powerOnLow, readyIn, sleepMode, pullReq} = 7'h4c;
    address = 2'h0;
    writedata = 32'h0;
    evt = 8'h0;
    cfg = 3'h5;
    boMode = RSS_BO_ON;
    cyc(20);
    rst <= 1'b0;
    cyc(5);
    powerOnLow <= 1'b0;
    for (int i = 0; i < 4; i++) rd(i[1:0], RST_VAL[i]);
    waitRun();
    for (int m = 0; m < 16; m++) begin
      boMode <= rss_bo_mode_t'(m[3:2]);
      sleepMode <= m[1];
      bus(2'h0, 1'b1, {m[0], 7'h40});
      cyc(3);
      expD = m[3:2] == 2'h3 || (m[3:2] == 2'h2 && !m[1]) || (m[3:2] == 2'h1 && m[0]);
      chk("detEn", {7'h0, expD}, {7'h0, detEn});
      chk("refOn", {7'h0, m[3:2] == 2'h1 || m[3:2] == 2'h2}, {7'h0, refOn});
      rd(2'h0, {m[0], 7'h41});
    end
    readyIn <= 1'b0;
    rd(2'h0, 8'hc0);
    readyIn <= 1'b1;
    sleepMode <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      cfg <= EV_CFG[i];
      bus(2'h1, 1'b1, 8'h1f);
      evt <= EV_VEC[i];
      cyc(EV_LEN[i]);
      evt <= 8'h00;
      cyc(3);
      chk("coreReset", {7'h0, EV_RST[i]}, {7'h0, coreReset});
      waitRun();
      rd(2'h1, EV_CAUSE[i]);
      rd(2'h2, (i < 4) ? 8'h01 : 8'h03);
    end
    cfg <= 3'h1;
    evt <= 8'h02;
    cyc(1);
    evt <= 8'h00;
    cyc(3);
    chk("coreReset", 8'h0, {7'h0, coreReset});
    for (int s = 0; s < 2; s++) begin
      cfg <= 3'h4;
      pullReq <= s[0];
      evt <= {!s[0], 7'h0};
      cyc(3);
      chk("pullEn", {7'h0, s[0]}, {7'h0, pullEn});
      chk("gpIn", {7'h0, s[0]}, {7'h0, gpIn});
    end
    giveVerdict();
  end
endmodule

// file: tb/rss_sequencer_props.sv
// Checker for the reset source sequencer: bus handshake, pin, mode and sequencing relations.
// Assumes it is bound to rss_reset_source_sequencer with the same PUD_CYCLES value.
`timescale 1ns/100ps
module rss_sequencer_props #(
  parameter int PUD_CYCLES = 40
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic powerOnLow,
  input wire logic powerUpDelayEnable_n,
  input wire logic stackOverflow,
  input wire logic stackResetEnable,
  input wire logic [1:0] brownOutModeField,
  input wire logic coreReset,
  input wire logic brownOutDetectEnable,
  input wire logic referenceForceOn,
  input wire logic externalResetPinOut,
  input wire logic externalResetPinOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] quietCnt_q;
  // Cycles since powerOnLow was last high; saturates so long runs never wrap
  always_ff @(posedge clk) begin
    if (rst || powerOnLow) begin
      quietCnt_q <= 32'h0;
    end else if (quietCnt_q != 32'hffffffff) begin
      quietCnt_q <= quietCnt_q + 32'h1;
    end
  end
  logic [7:0] heldCnt_q;
  // Cycles the core has been held; a counter, since a long repetition unrolls badly
  always_ff @(posedge clk) begin
    if (rst || !coreReset) begin
      heldCnt_q <= 8'h00;
    end else if (heldCnt_q != 8'hff) begin
      heldCnt_q <= heldCnt_q + 8'h01;
    end
  end
  sequence sReleased;
    $fell(coreReset);
  endsequence
  AST_PIN_NEVER_DRIVEN: assert property (!externalResetPinOe && !externalResetPinOut)
    else $error("reset pin driven");
  AST_ACK_NEXT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered in one cycle");
  AST_POWER_HOLD: assert property (powerOnLow |-> ##[1:2] coreReset)
    else $error("power event did not hold core");
  AST_DELAY_FULL: assert property ($fell(coreReset) && !powerUpDelayEnable_n |-> quietCnt_q >= PUD_CYCLES + 10)
    else $error("core released before power-up delay");
  AST_STACK_RESET: assert property (stackOverflow && stackResetEnable && !coreReset |-> ##[1:2] coreReset)
    else $error("stack fault did not reset");
  AST_RESTART_GAP: assert property (sReleased |-> heldCnt_q >= 8'h0a)
    else $error("restart gap too short");
  AST_FAST_START: assert property (referenceForceOn |-> ($past(brownOutModeField) == 2'h1 || $past(brownOutModeField) == 2'h2))
    else $error("reference forced in wrong mode");
  AST_MODE_OFF: assert property ((brownOutModeField == 2'h0) [*2] |-> !brownOutDetectEnable)
    else $error("detection on in off mode");
  AST_MODE_ON: assert property ((brownOutModeField == 2'h3) [*2] |-> brownOutDetectEnable)
    else $error("detection off in always-on mode");
endmodule
bind rss_reset_source_sequencer rss_sequencer_props #(.PUD_CYCLES(PUD_CYCLES)) u_props (.clk, .rst, .read, .write,
  .waitrequest, .powerOnLow, .powerUpDelayEnable_n, .stackOverflow, .stackResetEnable, .brownOutModeField,
  .coreReset, .brownOutDetectEnable, .referenceForceOn, .externalResetPinOut, .externalResetPinOe);
